//--- pkg/slb_pkg.sv
// constants and types for the software-pipelined loop branch unit
// assumes a single core clock; no bus, all controls are plain ports
`default_nettype none
package slb_pkg;
	// ********************************
	// widths and rotating area sizes
	// ********************************
	localparam int LOOP_CNT_W = 64;
	localparam int EPI_CNT_W = 6;
	localparam int PR_W = 6;
	localparam int FR_W = 7;
	localparam int GR_W = 7;
	localparam logic [PR_W-1:0] PRED_ROT_N = 6'h30;
	localparam logic [FR_W-1:0] FR_ROT_N = 7'h60;
	localparam logic [GR_W-1:0] GR_ROT_MAX = 7'h60;
	localparam logic [GR_W-1:0] GR_ROT_STEP_MASK = 7'h78;
	localparam logic [PR_W-1:0] PRED_HIGH_OFS = 6'h2F;
	localparam logic [LOOP_CNT_W-1:0] LOOP_CNT_RESET = 64'h0000000000000000;
	localparam logic [EPI_CNT_W-1:0] EPI_CNT_RESET = 6'h00;
	localparam logic [EPI_CNT_W-1:0] EPI_CNT_ONE = 6'h01;
	localparam logic [LOOP_CNT_W-1:0] LOOP_CNT_ONE = 64'h0000000000000001;
	localparam logic [PR_W-1:0] PR_ONE = 6'h01;
	localparam logic [FR_W-1:0] FR_ONE = 7'h01;
	localparam logic [GR_W-1:0] GR_ONE = 7'h01;

	// ********************************
	// branch kinds
	// ********************************
	typedef enum logic [3:0] {
		SLB_COUNTED_TOP = 4'h1,
		SLB_COUNTED_EXIT = 4'h2,
		SLB_WHILE_TOP = 4'h4,
		SLB_WHILE_EXIT = 4'h8
	} slb_kind_e;
endpackage : slb_pkg
`default_nettype wire

//--- pkg/slb_pred_if.sv
// carrier between the branch unit and its rotating predicate file
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface slb_pred_if;
	logic we;
	logic [slb_pkg::PR_W-1:0] waddr;
	logic wdata;
	logic [slb_pkg::PR_W-1:0] raddr;
	logic rdata;
	logic init_valid;
	logic [47:0] init_value;
	modport owner (output we, waddr, wdata, raddr, init_valid, init_value, input rdata);
	modport file (input we, waddr, wdata, raddr, init_valid, init_value, output rdata);
endinterface : slb_pred_if
`default_nettype wire

//--- design/slb_pred_file.sv
// physical rotating predicate file, 48 entries, registered read
// assumes active-low asynchronous reset from the owner, released in step with clk
`timescale 1ns/1ps
`default_nettype none
module slb_pred_file (
	input wire logic clk,
	input wire logic rst_n,
	slb_pred_if.file pif
);
	logic [47:0] pf;
	logic [47:0] next_pf;
	logic next_rdata;

	// ********************************
	// write, bulk init and bypass read
	// ********************************
	always_comb begin
		next_pf = pif.init_valid ? pif.init_value : pf;
		if (pif.we) begin
			next_pf[pif.waddr] = pif.wdata;
		end
	end
	assign next_rdata = next_pf[pif.raddr];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pf <= 48'h000000000000;
			pif.rdata <= 1'b0;
		end else begin
			pf <= next_pf;
			pif.rdata <= next_rdata;
		end
	end
endmodule : slb_pred_file
`default_nettype wire

//--- design/slb_branch.sv
// software-pipelined loop branch resolution with rotating bases
// assumes the core presents one branch per cycle and loads only when idle
`timescale 1ns/1ps
`default_nettype none
module slb_branch (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic branch_valid,
	input wire slb_pkg::slb_kind_e branch_kind,
	input wire logic branch_pred,
	input wire logic loop_cnt_load,
	input wire logic [slb_pkg::LOOP_CNT_W-1:0] loop_cnt_load_value,
	input wire logic epi_cnt_load,
	input wire logic [slb_pkg::EPI_CNT_W-1:0] epi_cnt_load_value,
	input wire logic frame_alloc,
	input wire logic [slb_pkg::GR_W-1:0] gr_rot_size,
	input wire logic pred_init,
	input wire logic [47:0] pred_init_value,
	output logic branch_done,
	output logic branch_taken,
	output logic loop_continue,
	output logic [slb_pkg::LOOP_CNT_W-1:0] loop_count_register,
	output logic [slb_pkg::EPI_CNT_W-1:0] epilog_count_register,
	output logic [slb_pkg::PR_W-1:0] rrb_pr,
	output logic [slb_pkg::FR_W-1:0] rrb_fr,
	output logic [slb_pkg::GR_W-1:0] rrb_gr,
	output logic [slb_pkg::GR_W-1:0] gr_rot_area,
	output logic first_stage_predicate
);
	// ********************************
	// reset release
	// ********************************
	logic rst_meta_n;
	logic rst_sync_n;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ********************************
	// decode helpers
	// ********************************
	function automatic logic kind_counted(input slb_pkg::slb_kind_e k);
		unique case (k)
			slb_pkg::SLB_COUNTED_TOP, slb_pkg::SLB_COUNTED_EXIT: kind_counted = 1'b1;
			slb_pkg::SLB_WHILE_TOP, slb_pkg::SLB_WHILE_EXIT: kind_counted = 1'b0;
			default: kind_counted = 1'b0;
		endcase
	endfunction : kind_counted

	function automatic logic kind_top(input slb_pkg::slb_kind_e k);
		unique case (k)
			slb_pkg::SLB_COUNTED_TOP, slb_pkg::SLB_WHILE_TOP: kind_top = 1'b1;
			slb_pkg::SLB_COUNTED_EXIT, slb_pkg::SLB_WHILE_EXIT: kind_top = 1'b0;
			default: kind_top = 1'b0;
		endcase
	endfunction : kind_top

	// wrap-around decrement of a rotating base
	function automatic logic [6:0] base_dec(input logic [6:0] b, input logic [6:0] n);
		if (n == 7'h00) begin
			base_dec = 7'h00;
		end else if (b == 7'h00) begin
			base_dec = n - 7'h01;
		end else begin
			base_dec = b - 7'h01;
		end
	endfunction : base_dec

	// ********************************
	// branch decision
	// ********************************
	wire is_counted = kind_counted(branch_kind);
	wire is_top = kind_top(branch_kind);
	wire loop_nz = loop_count_register != slb_pkg::LOOP_CNT_RESET;
	wire epi_nz = epilog_count_register != slb_pkg::EPI_CNT_RESET;
	wire epi_gt1 = epilog_count_register > slb_pkg::EPI_CNT_ONE;
	wire new_iter = is_counted ? loop_nz : branch_pred;
	wire cont = new_iter || epi_gt1;
	wire rotate = branch_valid && (new_iter || epi_nz);
	wire dec_loop = branch_valid && is_counted && loop_nz;
	wire dec_epi = branch_valid && !new_iter && epi_nz;
	wire stage_val = is_counted && new_iter;
	wire taken = is_top ? cont : !cont;

	// ********************************
	// next values
	// ********************************
	wire [slb_pkg::GR_W-1:0] sor_masked = gr_rot_size & slb_pkg::GR_ROT_STEP_MASK;
	wire [slb_pkg::GR_W-1:0] sor_in =
		(sor_masked > slb_pkg::GR_ROT_MAX) ? slb_pkg::GR_ROT_MAX : sor_masked;
	wire [6:0] pr_dec_full = base_dec({1'b0, rrb_pr}, {1'b0, slb_pkg::PRED_ROT_N});
	wire [slb_pkg::PR_W-1:0] pr_dec = pr_dec_full[slb_pkg::PR_W-1:0];
	wire [slb_pkg::FR_W-1:0] fr_dec = base_dec(rrb_fr, slb_pkg::FR_ROT_N);
	wire [slb_pkg::GR_W-1:0] gr_dec = base_dec(rrb_gr, gr_rot_area);
	wire [slb_pkg::PR_W-1:0] next_rrb_pr = frame_alloc ? '0 : (rotate ? pr_dec : rrb_pr);
	wire [slb_pkg::FR_W-1:0] next_rrb_fr = frame_alloc ? '0 : (rotate ? fr_dec : rrb_fr);
	wire [slb_pkg::GR_W-1:0] next_rrb_gr = frame_alloc ? '0 : (rotate ? gr_dec : rrb_gr);
	wire [6:0] hi_sum = {1'b0, rrb_pr} + {1'b0, slb_pkg::PRED_HIGH_OFS};
	wire [slb_pkg::PR_W-1:0] hi_phys = (hi_sum >= {1'b0, slb_pkg::PRED_ROT_N}) ?
		hi_sum[5:0] - slb_pkg::PRED_ROT_N : hi_sum[5:0];
	wire [slb_pkg::LOOP_CNT_W-1:0] next_loop_cnt = dec_loop ?
		loop_count_register - slb_pkg::LOOP_CNT_ONE :
		((loop_cnt_load && !branch_valid) ? loop_cnt_load_value : loop_count_register);
	wire [slb_pkg::EPI_CNT_W-1:0] next_epi_cnt = dec_epi ?
		epilog_count_register - slb_pkg::EPI_CNT_ONE :
		((epi_cnt_load && !branch_valid) ? epi_cnt_load_value : epilog_count_register);

	// ********************************
	// rotating predicate file
	// ********************************
	slb_pred_if pif ();
	assign pif.we = branch_valid;
	assign pif.waddr = hi_phys;
	assign pif.wdata = stage_val;
	assign pif.raddr = next_rrb_pr;
	assign pif.init_valid = pred_init && !branch_valid;
	assign pif.init_value = pred_init_value;

	slb_pred_file u_pred (
		.clk(clk),
		.rst_n(rst_sync_n),
		.pif(pif)
	);
	assign first_stage_predicate = pif.rdata;

	// ********************************
	// architectural state
	// ********************************
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			loop_count_register <= slb_pkg::LOOP_CNT_RESET;
			epilog_count_register <= slb_pkg::EPI_CNT_RESET;
		end else begin
			loop_count_register <= next_loop_cnt;
			epilog_count_register <= next_epi_cnt;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rrb_pr <= '0;
			rrb_fr <= '0;
			rrb_gr <= '0;
			gr_rot_area <= '0;
		end else begin
			rrb_pr <= next_rrb_pr;
			rrb_fr <= next_rrb_fr;
			rrb_gr <= next_rrb_gr;
			gr_rot_area <= frame_alloc ? sor_in : gr_rot_area;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			branch_done <= 1'b0;
			branch_taken <= 1'b0;
			loop_continue <= 1'b0;
		end else begin
			branch_done <= branch_valid;
			branch_taken <= branch_valid && taken;
			loop_continue <= branch_valid && cont;
		end
	end

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_n);

	property p_kernel;
		branch_valid && is_counted && loop_nz |=> loop_continue && first_stage_predicate
			&& loop_count_register == $past(loop_count_register) - slb_pkg::LOOP_CNT_ONE
			&& $stable(epilog_count_register);
	endproperty
	a_kernel: assert property (p_kernel) else $error("kernel action wrong");

	property p_epilog;
		branch_valid && is_counted && !loop_nz && epi_gt1 |=> loop_continue
			&& !first_stage_predicate
			&& epilog_count_register == $past(epilog_count_register) - slb_pkg::EPI_CNT_ONE;
	endproperty
	a_epilog: assert property (p_epilog) else $error("epilog action wrong");

	property p_final;
		branch_valid && !new_iter && epilog_count_register == slb_pkg::EPI_CNT_ONE
			|=> !loop_continue && epilog_count_register == slb_pkg::EPI_CNT_RESET
			&& rrb_pr != $past(rrb_pr) && !first_stage_predicate;
	endproperty
	a_final: assert property (p_final) else $error("final exit wrong");

	property p_epi_zero;
		branch_valid && !new_iter && !epi_nz |=> !loop_continue && $stable(rrb_pr)
			&& epilog_count_register == slb_pkg::EPI_CNT_RESET;
	endproperty
	a_epi_zero: assert property (p_epi_zero) else $error("zero epilog count wrong");

	property p_top;
		branch_valid && is_top |=> branch_taken == loop_continue;
	endproperty
	a_top: assert property (p_top) else $error("top variant direction wrong");

	property p_exit;
		branch_valid && !is_top |=> branch_taken != loop_continue;
	endproperty
	a_exit: assert property (p_exit) else $error("exit variant direction wrong");

	property p_while_loop;
		branch_valid && !is_counted && !loop_cnt_load |=> $stable(loop_count_register)
			&& loop_continue == ($past(branch_pred) || $past(epi_gt1));
	endproperty
	a_while_loop: assert property (p_while_loop) else $error("while touched loop count");

	property p_while_fsp;
		branch_valid && !is_counted |=> !first_stage_predicate;
	endproperty
	a_while_fsp: assert property (p_while_fsp) else $error("while left stage set");

	property p_wrap;
		rotate && !frame_alloc && rrb_pr == '0 |=> rrb_pr == slb_pkg::PRED_ROT_N - slb_pkg::PR_ONE
			&& rrb_fr == ($past(rrb_fr) == '0 ? slb_pkg::FR_ROT_N - slb_pkg::FR_ONE
			: $past(rrb_fr) - slb_pkg::FR_ONE);
	endproperty
	a_wrap: assert property (p_wrap) else $error("base wrap wrong");

	c_kernel: cover property (branch_valid && is_counted && loop_nz);
	c_epilog_exit: cover property (branch_valid
		&& epilog_count_register == slb_pkg::EPI_CNT_ONE && !new_iter);
	c_while_cont: cover property (branch_valid && !is_counted && branch_pred);
	c_epi_zero: cover property (branch_valid && !new_iter && !epi_nz);
endmodule : slb_branch
`default_nettype wire

//--- test/slb_core_model.sv
// core-side stream model: loads counts, issues loop branches
// assumes one calling process, signals change just after clk rises
`timescale 1ns/1ps
`default_nettype none
module slb_core_model (
	input wire logic clk,
	output logic branch_valid,
	output var slb_pkg::slb_kind_e branch_kind,
	output logic branch_pred,
	output logic loop_cnt_load,
	output logic [slb_pkg::LOOP_CNT_W-1:0] loop_cnt_load_value,
	output logic epi_cnt_load,
	output logic [slb_pkg::EPI_CNT_W-1:0] epi_cnt_load_value,
	output logic frame_alloc,
	output logic [slb_pkg::GR_W-1:0] gr_rot_size,
	output logic pred_init,
	output logic [47:0] pred_init_value
);
	initial begin
		{branch_valid, branch_pred, loop_cnt_load, epi_cnt_load, frame_alloc, pred_init} = 6'h00;
		branch_kind = slb_pkg::SLB_COUNTED_TOP;
		loop_cnt_load_value = 64'h0;
		epi_cnt_load_value = 6'h00;
		gr_rot_size = 7'h00;
		pred_init_value = 48'h0;
	end
	// ********************************
	// loop setup and branch issue
	// ********************************
	task automatic setup(input int iters, input int stages, input logic [6:0] size);
		@(posedge clk);
		loop_cnt_load <= 1'b1;
		loop_cnt_load_value <= 64'(iters - 1);
		epi_cnt_load <= 1'b1;
		epi_cnt_load_value <= 6'(stages + 1);
		frame_alloc <= 1'b1;
		gr_rot_size <= size;
		pred_init <= 1'b1;
		pred_init_value <= 48'h000000000001;
		@(posedge clk);
		{loop_cnt_load, epi_cnt_load, frame_alloc, pred_init} <= 4'h0;
		loop_cnt_load_value <= ~loop_cnt_load_value;
		epi_cnt_load_value <= ~epi_cnt_load_value;
	endtask : setup
	task automatic issue(input slb_pkg::slb_kind_e k, input logic p);
		@(posedge clk);
		branch_valid <= 1'b1;
		branch_kind <= k;
		branch_pred <= p;
		@(posedge clk);
		branch_valid <= 1'b0;
		branch_pred <= ~p;
	endtask : issue
endmodule : slb_core_model
`default_nettype wire

//--- test/tb_top.sv
// bench for the loop branch unit, driving it through the core model
// assumes the 20 MHz clock and one branch answer a cycle later
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	wire logic bv, bp, lcl, ecl, fa, pi, done, taken, cont, fsp_o;
	slb_pkg::slb_kind_e bk;
	wire logic [63:0] lcv, cnt_o;
	wire logic [5:0] ecv, epi_o, pr_o;
	wire logic [6:0] grs, fr_o, gr_o, area_o;
	wire logic [47:0] piv;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [63:0] cnt_exp;
	logic [5:0] epi_exp, pr;
	logic [6:0] fr, gr, area;
	logic fsp;
	always #25 clk = ~clk;
	slb_core_model core_u (.clk(clk), .branch_valid(bv), .branch_kind(bk), .branch_pred(bp),
		.loop_cnt_load(lcl), .loop_cnt_load_value(lcv), .epi_cnt_load(ecl),
		.epi_cnt_load_value(ecv), .frame_alloc(fa), .gr_rot_size(grs), .pred_init(pi),
		.pred_init_value(piv));
	slb_branch dut_u (.clk(clk), .rst_n(rst_n), .branch_valid(bv), .branch_kind(bk),
		.branch_pred(bp), .loop_cnt_load(lcl), .loop_cnt_load_value(lcv), .epi_cnt_load(ecl),
		.epi_cnt_load_value(ecv), .frame_alloc(fa), .gr_rot_size(grs), .pred_init(pi),
		.pred_init_value(piv), .branch_done(done), .branch_taken(taken),
		.loop_continue(cont), .loop_count_register(cnt_o), .epilog_count_register(epi_o),
		.rrb_pr(pr_o), .rrb_fr(fr_o), .rrb_gr(gr_o), .gr_rot_area(area_o),
		.first_stage_predicate(fsp_o));
	// ********************************
	// reporting
	// ********************************
	task automatic wrap_up;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			wrap_up();
		end
	end
	// ********************************
	// shared steps
	// ********************************
	task automatic load(input int it, input int st, input logic [6:0] sz, input logic [6:0] ar);
		core_u.setup(it, st, sz);
		#1;
		{cnt_exp, epi_exp, pr, fr, gr, area, fsp} = {64'(it - 1), 6'(st + 1), 20'h0, ar, 1'b1};
		chk("area", area_o, ar);
		chk("loop_cnt", cnt_o, cnt_exp);
		chk("epi_cnt", epi_o, epi_exp);
		chk("fsp_init", fsp_o, fsp);
	endtask : load
	task automatic step(input slb_pkg::slb_kind_e k, input logic p);
		logic cnt, nw, cn, rot;
		cnt = (k == slb_pkg::SLB_COUNTED_TOP) || (k == slb_pkg::SLB_COUNTED_EXIT);
		nw = cnt ? (cnt_exp != 64'h0) : p;
		cn = nw || (epi_exp > 6'h01);
		rot = nw || (epi_exp != 6'h00);
		core_u.issue(k, p);
		#1;
		chk("done", done, 1'b1);
		chk("cont", cont, cn);
		chk("taken", taken, (k inside {4'h1, 4'h4}) ? cn : !cn);
		if (cnt && cnt_exp != 64'h0) cnt_exp = cnt_exp - 64'h1;
		if (!nw && epi_exp != 6'h00) epi_exp = epi_exp - 6'h01;
		if (rot) begin
			pr = (pr == 6'h00) ? 6'h2F : pr - 6'h01;
			fr = (fr == 7'h00) ? 7'h5F : fr - 7'h01;
			gr = (area == 7'h00) ? 7'h00 : ((gr == 7'h00) ? area - 7'h01 : gr - 7'h01);
			fsp = cnt && nw;
		end
		chk("loop_cnt", cnt_o, cnt_exp);
		chk("epi_cnt", epi_o, epi_exp);
		chk("rrb_pr", pr_o, pr);
		chk("rrb_fr", fr_o, fr);
		chk("rrb_gr", gr_o, gr);
		chk("fsp", fsp_o, fsp);
	endtask : step
	// ********************************
	// scenarios
	// ********************************
	task automatic t_counted_top;
		int n = 0;
		load(3, 3, 7'h10, 7'h10);
		do begin
			step(slb_pkg::SLB_COUNTED_TOP, 1'b0);
			n++;
		end while (cont === 1'b1 && n < 20);
		chk("drain", n, 6);
		chk("epi_end", epi_o, 6'h00);
		chk("fsp_end", fsp_o, 1'b0);
	endtask : t_counted_top
	task automatic t_counted_exit;
		load(1, 0, 7'h7F, 7'h60);
		step(slb_pkg::SLB_COUNTED_EXIT, 1'b1);
		step(slb_pkg::SLB_COUNTED_EXIT, 1'b0);
	endtask : t_counted_exit
	task automatic t_while;
		load(5, 1, 7'h00, 7'h00);
		step(slb_pkg::SLB_WHILE_TOP, 1'b1);
		step(slb_pkg::SLB_WHILE_EXIT, 1'b1);
		step(slb_pkg::SLB_WHILE_EXIT, 1'b0);
		step(slb_pkg::SLB_WHILE_TOP, 1'b0);
	endtask : t_while
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_counted_top();
		t_counted_exit();
		t_while();
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
